// ---- hw/panel_lamp_params.svh ----
// Timing figures, counts and widths for the front-panel lamp logic
`ifndef PANEL_LAMP_PARAMS_SVH
`define PANEL_LAMP_PARAMS_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define MS_TICK_NS 1000000

// ----------------------------------------
// Lamp timing, in milliseconds
// ----------------------------------------
`define GEN1_HALF_MS 1000
`define GEN2_HALF_MS 500
`define PPS_FLASH_MS 100
`define OVL_HOLD_MS 50

// ----------------------------------------
// Counts and widths
// ----------------------------------------
`define MS_CNT_W 11
`define NUM_CH 4
`define NUM_THERM 4
`define SAMP_W 16

`endif

// ---- hw/panel_lamp_pkg.sv ----
// Types shared by the front-panel lamp logic
package panel_lamp_pkg;

   // ----------------------------------------
   // Trained link speed code
   // ----------------------------------------
   typedef enum logic [1:0] {
      SPEED_NONE = 2'h0,
      SPEED_GEN1 = 2'h1,
      SPEED_GEN2 = 2'h2,
      SPEED_GEN3 = 2'h3
   } link_speed_e;

   // ----------------------------------------
   // Link lamp pattern states
   // ----------------------------------------
   typedef enum logic [3:0] {
      LINK_DARK = 4'h1,
      LINK_SLOW = 4'h2,
      LINK_MED = 4'h4,
      LINK_STEADY = 4'h8
   } link_lamp_e;

endpackage

// ---- hw/front_panel_status_leds.sv ----
// Front-panel status lamp driver for a four-channel acquisition module
`include "panel_lamp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module front_panel_status_leds #(
   parameter int unsigned TICK_CYC = `MS_TICK_NS / `CLK_PERIOD_NS,
   parameter int unsigned NUM_CH = `NUM_CH,
   parameter int unsigned NUM_THERM = `NUM_THERM,
   parameter int unsigned SAMP_W = `SAMP_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link status, same clock
   input wire logic link_up,
   input wire panel_lamp_pkg::link_speed_e link_speed,
   // Configuration and user
   input wire logic bus_master_cfg,
   input wire logic user_lamp_req,
   // Asynchronous status inputs
   input wire logic pps_pulse,
   input wire logic pps_valid,
   input wire logic samp_clk_detect,
   input wire logic [NUM_THERM-1:0] therm_alarm,
   input wire logic [NUM_CH-1:0] adc_overload,
   input wire logic [NUM_CH-1:0] fifo_overrun,
   // Sample stream
   input wire logic samp_valid_in,
   input wire logic [SAMP_W-1:0] samp_data_in,
   output logic samp_valid_out,
   output logic [SAMP_W-1:0] samp_data_out,
   // Lamps
   output logic link_speed_lamp,
   output logic user_lamp,
   output logic bus_master_lamp,
   output logic pulse_lamp,
   output logic thermal_alarm_lamp,
   output logic clock_lamp,
   output logic [NUM_CH-1:0] overload_lamp
);
   import panel_lamp_pkg::*;

   localparam int unsigned SW = 3 + NUM_THERM + 2 * NUM_CH;
   localparam int unsigned TW = $clog2(TICK_CYC + 1);
   localparam logic [`MS_CNT_W-1:0] G1_HALF = `MS_CNT_W'(`GEN1_HALF_MS);
   localparam logic [`MS_CNT_W-1:0] G2_HALF = `MS_CNT_W'(`GEN2_HALF_MS);
   localparam logic [`MS_CNT_W-1:0] FLASH_MS = `MS_CNT_W'(`PPS_FLASH_MS);
   localparam logic [`MS_CNT_W-1:0] HOLD_MS = `MS_CNT_W'(`OVL_HOLD_MS);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [SW-1:0] async_in;
   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   logic pps_s;
   logic pps_ok_s;
   logic clk_ok_s;
   logic [NUM_THERM-1:0] therm_s;
   logic [NUM_CH-1:0] ovl_s;
   logic [NUM_CH-1:0] ovr_s;
   assign async_in = {fifo_overrun, adc_overload, therm_alarm,
                      samp_clk_detect, pps_valid, pps_pulse};
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= async_in;
         sync2_ff <= sync1_ff;
      end
   end
   assign pps_s = sync2_ff[0];
   assign pps_ok_s = sync2_ff[1];
   assign clk_ok_s = sync2_ff[2];
   assign therm_s = sync2_ff[3 +: NUM_THERM];
   assign ovl_s = sync2_ff[3 + NUM_THERM +: NUM_CH];
   assign ovr_s = sync2_ff[3 + NUM_THERM + NUM_CH +: NUM_CH];

   // ----------------------------------------
   // Millisecond tick divider
   // ----------------------------------------
   logic [TW-1:0] tick_cnt_ff;
   logic [TW-1:0] nxt_tick_cnt;
   logic ms_tick;
   assign ms_tick = (tick_cnt_ff == TW'(TICK_CYC - 1));
   always_comb begin
      nxt_tick_cnt = ms_tick ? '0 : tick_cnt_ff + TW'(1);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   // ----------------------------------------
   // Link lamp pattern
   // ----------------------------------------
   link_lamp_e link_st_ff;
   link_lamp_e nxt_link_st;
   logic [`MS_CNT_W-1:0] blink_cnt_ff;
   logic [`MS_CNT_W-1:0] nxt_blink_cnt;
   logic [`MS_CNT_W-1:0] half_ms;
   logic link_lamp_ff;
   logic nxt_link_lamp;

   always_comb begin
      nxt_link_st = LINK_DARK;
      if (link_up) begin
         unique case (link_speed)
            SPEED_GEN1: nxt_link_st = LINK_SLOW;
            SPEED_GEN2: nxt_link_st = LINK_MED;
            SPEED_GEN3: nxt_link_st = LINK_STEADY;
            SPEED_NONE: nxt_link_st = LINK_DARK;
         endcase
      end
   end
   // Restart the blink phase on every pattern change, lit unless the new pattern is dark, so a new speed shows at once
   always_comb begin
      half_ms = (link_st_ff == LINK_SLOW) ? G1_HALF : G2_HALF;
      nxt_blink_cnt = blink_cnt_ff;
      nxt_link_lamp = link_lamp_ff;
      if (nxt_link_st != link_st_ff) begin
         nxt_blink_cnt = '0;
         nxt_link_lamp = (nxt_link_st != LINK_DARK);
      end else begin
         unique case (link_st_ff)
            LINK_DARK: nxt_link_lamp = 1'b0;
            LINK_STEADY: nxt_link_lamp = 1'b1;
            LINK_SLOW, LINK_MED: begin
               if (ms_tick) begin
                  if (blink_cnt_ff == half_ms - `MS_CNT_W'(1)) begin
                     nxt_blink_cnt = '0;
                     nxt_link_lamp = ~link_lamp_ff;
                  end else begin
                     nxt_blink_cnt = blink_cnt_ff + `MS_CNT_W'(1);
                  end
               end
            end
            default: nxt_link_lamp = 1'b0;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         link_st_ff <= LINK_DARK;
         blink_cnt_ff <= '0;
         link_lamp_ff <= 1'b0;
      end else begin
         link_st_ff <= nxt_link_st;
         blink_cnt_ff <= nxt_blink_cnt;
         link_lamp_ff <= nxt_link_lamp;
      end
   end
   assign link_speed_lamp = link_lamp_ff;

   // ----------------------------------------
   // Pulse-per-second flash
   // ----------------------------------------
   logic pps_dly_ff;
   logic [`MS_CNT_W-1:0] flash_cnt_ff;
   logic [`MS_CNT_W-1:0] nxt_flash_cnt;
   logic pps_rise;
   assign pps_rise = pps_s & ~pps_dly_ff & pps_ok_s;
   // Fixed-length flash so the lamp follows the pulse rate, not pulse width
   always_comb begin
      nxt_flash_cnt = flash_cnt_ff;
      if (pps_rise) begin
         nxt_flash_cnt = FLASH_MS;
      end else if (!pps_ok_s) begin
         nxt_flash_cnt = '0;
      end else if (ms_tick && flash_cnt_ff != '0) begin
         nxt_flash_cnt = flash_cnt_ff - `MS_CNT_W'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         pps_dly_ff <= 1'b0;
         flash_cnt_ff <= '0;
      end else begin
         pps_dly_ff <= pps_s;
         flash_cnt_ff <= nxt_flash_cnt;
      end
   end
   assign pulse_lamp = (flash_cnt_ff != '0);

   // ----------------------------------------
   // Overload lamps with hold time
   // ----------------------------------------
   // Unpacked, so each channel's processes own whole words of their own
   logic [`MS_CNT_W-1:0] hold_ff [NUM_CH];
   logic [`MS_CNT_W-1:0] nxt_hold [NUM_CH];
   // A single-sample overload is stretched, or nobody would ever see it
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ovl
      always_comb begin
         nxt_hold[ch] = hold_ff[ch];
         if (ovl_s[ch] || ovr_s[ch]) begin
            nxt_hold[ch] = HOLD_MS;
         end else if (ms_tick && hold_ff[ch] != '0) begin
            nxt_hold[ch] = hold_ff[ch] - `MS_CNT_W'(1);
         end
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            hold_ff[ch] <= '0;
         end else begin
            hold_ff[ch] <= nxt_hold[ch];
         end
      end
      assign overload_lamp[ch] = (hold_ff[ch] != '0);
   end

   // ----------------------------------------
   // Steady lamps and sample gate
   // ----------------------------------------
   logic master_ff;
   logic user_ff;
   logic therm_ff;
   logic clk_lamp_ff;
   logic sv_ff;
   logic [SAMP_W-1:0] sd_ff;
   logic nxt_master;
   logic nxt_user;
   logic nxt_therm;
   logic nxt_clk_lamp;
   logic nxt_sv;
   logic [SAMP_W-1:0] nxt_sd;

   always_comb begin
      nxt_master = bus_master_cfg;
      nxt_user = user_lamp_req;
      nxt_therm = |therm_s;
      nxt_clk_lamp = clk_ok_s;
      nxt_sv = samp_valid_in & clk_ok_s;
      nxt_sd = nxt_sv ? samp_data_in : sd_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         master_ff <= 1'b0;
         user_ff <= 1'b0;
         therm_ff <= 1'b0;
         clk_lamp_ff <= 1'b0;
         sv_ff <= 1'b0;
         sd_ff <= '0;
      end else begin
         master_ff <= nxt_master;
         user_ff <= nxt_user;
         therm_ff <= nxt_therm;
         clk_lamp_ff <= nxt_clk_lamp;
         sv_ff <= nxt_sv;
         sd_ff <= nxt_sd;
      end
   end

   assign bus_master_lamp = master_ff;
   assign user_lamp = user_ff;
   assign thermal_alarm_lamp = therm_ff;
   assign clock_lamp = clk_lamp_ff;
   assign samp_valid_out = sv_ff;
   assign samp_data_out = sd_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_gen1_toggle;
      link_st_ff == LINK_SLOW && link_up && link_speed == SPEED_GEN1 && ms_tick
         && blink_cnt_ff == G1_HALF - `MS_CNT_W'(1) |=> link_speed_lamp != $past(link_speed_lamp);
   endproperty
   a_gen1_toggle: assert property (p_gen1_toggle) else $error("gen1 blink missed");
   property p_gen2_toggle;
      link_st_ff == LINK_MED && link_up && link_speed == SPEED_GEN2 && ms_tick
         && blink_cnt_ff == G2_HALF - `MS_CNT_W'(1) |=> link_speed_lamp != $past(link_speed_lamp);
   endproperty
   a_gen2_toggle: assert property (p_gen2_toggle) else $error("gen2 blink missed");
   property p_gen3_steady;
      link_up && link_speed == SPEED_GEN3 |=> link_speed_lamp;
   endproperty
   a_gen3_steady: assert property (p_gen3_steady) else $error("gen3 lamp not lit");
   property p_no_link_dark;
      !link_up |=> !link_speed_lamp;
   endproperty
   a_no_link_dark: assert property (p_no_link_dark) else $error("link lamp lit without link");
   // Both directions: lit while configured, dark otherwise
   property p_master;
      1'b1 |=> bus_master_lamp == $past(bus_master_cfg);
   endproperty
   a_master: assert property (p_master) else $error("master lamp wrong");
   property p_pps_flash;
      pps_rise |=> pulse_lamp [*2];
   endproperty
   a_pps_flash: assert property (p_pps_flash) else $error("pps flash missing");
   property p_therm;
      therm_s != '0 |=> thermal_alarm_lamp;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal lamp not lit");
   property p_clk_lamp;
      !clk_ok_s |=> !clock_lamp;
   endproperty
   a_clk_lamp: assert property (p_clk_lamp) else $error("clock lamp lit without clock");
   property p_no_samples;
      !clk_ok_s |=> !samp_valid_out;
   endproperty
   a_no_samples: assert property (p_no_samples) else $error("sample passed without clock");
   property p_ovl;
      ovl_s[0] || ovr_s[0] |=> overload_lamp[0];
   endproperty
   a_ovl: assert property (p_ovl) else $error("overload lamp not lit");
   property p_user;
      1'b1 |=> user_lamp == $past(user_lamp_req);
   endproperty
   a_user: assert property (p_user) else $error("user lamp mismatch");
   c_gen1: cover property (link_st_ff == LINK_SLOW && ms_tick && blink_cnt_ff == G1_HALF - `MS_CNT_W'(1));
   c_gen3: cover property (link_st_ff == LINK_STEADY);
   c_pps: cover property (pps_rise);
   c_ovr: cover property (ovr_s[3] && !ovl_s[3]);

endmodule // front_panel_status_leds

`default_nettype wire

// ---- tb/lamp_viewer.sv ----
// Operator view of the link lamp: counts every change of its state
`timescale 1ns/1ps
`default_nettype none

module lamp_viewer (
   // Clock and control
   input wire logic clk,
   input wire logic clear,
   // Lamp seen and its change count
   input wire logic link_speed_lamp,
   output logic [7:0] changes_ff
);
   logic last_ff;

   // An eye sees only changes, so a steady lamp counts nothing
   always_ff @(posedge clk) begin
      last_ff <= link_speed_lamp;
      if (clear) begin
         changes_ff <= 8'h00;
      end else if (link_speed_lamp != last_ff) begin
         changes_ff <= changes_ff + 8'h01;
      end
   end
endmodule // lamp_viewer
`default_nettype wire

// ---- tb/front_panel_status_leds_test.sv ----
// Self-checking bench for the front-panel lamp driver
`timescale 1ns/1ps
`default_nettype none

module front_panel_status_leds_test;
   import panel_lamp_pkg::*;
   // ------------------------------
   // Stimulus, outputs and counters
   // ------------------------------
   localparam int TICK = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic link_up = 1'b0;
   link_speed_e link_speed = SPEED_NONE;
   logic bus_master_cfg = 1'b0;
   logic user_lamp_req = 1'b0;
   logic pps_pulse = 1'b0;
   logic pps_valid = 1'b0;
   logic samp_clk_detect = 1'b0;
   logic [3:0] therm_alarm = 4'h0;
   logic [3:0] adc_overload = 4'h0;
   logic [3:0] fifo_overrun = 4'h0;
   logic samp_valid_in = 1'b0;
   logic [15:0] samp_data_in = 16'h0000;
   logic samp_valid_out, link_speed_lamp, user_lamp, bus_master_lamp;
   logic pulse_lamp, thermal_alarm_lamp, clock_lamp;
   logic [15:0] samp_data_out;
   logic [3:0] overload_lamp;
   logic clear = 1'b0;
   logic [7:0] changes;
   int err_count = 0;
   int total_checks = 0;
   int cycle_cnt = 0;

   always #2 clk = ~clk;

   front_panel_status_leds #(.TICK_CYC(TICK)) front_panel_status_leds_i (.clk(clk), .rst(rst),
      .link_up(link_up), .link_speed(link_speed), .bus_master_cfg(bus_master_cfg),
      .user_lamp_req(user_lamp_req), .pps_pulse(pps_pulse), .pps_valid(pps_valid),
      .samp_clk_detect(samp_clk_detect), .therm_alarm(therm_alarm), .adc_overload(adc_overload),
      .fifo_overrun(fifo_overrun), .samp_valid_in(samp_valid_in), .samp_data_in(samp_data_in),
      .samp_valid_out(samp_valid_out), .samp_data_out(samp_data_out),
      .link_speed_lamp(link_speed_lamp), .user_lamp(user_lamp), .bus_master_lamp(bus_master_lamp),
      .pulse_lamp(pulse_lamp), .thermal_alarm_lamp(thermal_alarm_lamp), .clock_lamp(clock_lamp),
      .overload_lamp(overload_lamp));

   lamp_viewer lamp_viewer_i (.clk(clk), .clear(clear), .link_speed_lamp(link_speed_lamp),
      .changes_ff(changes));

   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 12400 cycles the scenarios need
   always @(posedge clk) begin
      cycle_cnt++;
      if (cycle_cnt == 30000) begin
         err_count++;
         test_done();
      end
   end

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_static();
      int i;
      @(posedge clk);
      user_lamp_req <= 1'b1;
      samp_clk_detect <= 1'b1;
      cyc(5);
      chk1(bus_master_lamp, 1'b0);
      chk1(user_lamp, 1'b1);
      chk1(clock_lamp, 1'b1);
      chk1(thermal_alarm_lamp, 1'b0);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         therm_alarm <= 4'h1 << i;
         cyc(5);
         chk1(thermal_alarm_lamp, 1'b1);
      end
      @(posedge clk);
      bus_master_cfg <= 1'b1;
      user_lamp_req <= 1'b0;
      samp_clk_detect <= 1'b0;
      therm_alarm <= 4'h0;
      cyc(5);
      chk1(bus_master_lamp, 1'b1);
      chk1(user_lamp, 1'b0);
      chk1(clock_lamp, 1'b0);
      chk1(thermal_alarm_lamp, 1'b0);
   endtask

   task automatic t_link(input link_speed_e sp, input logic up, input logic lit, input int win,
                         input logic [7:0] n);
      @(posedge clk);
      link_up <= up;
      link_speed <= sp;
      cyc(3);
      chk1(link_speed_lamp, lit);
      @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      cyc(win);
      chkv({8'h00, changes}, {8'h00, n});
   endtask

   task automatic t_pps();
      @(posedge clk);
      pps_valid <= 1'b1;
      cyc(4);
      @(posedge clk);
      pps_pulse <= 1'b1;
      cyc(5);
      chk1(pulse_lamp, 1'b1);
      @(posedge clk);
      pps_pulse <= 1'b0;
      cyc(100 * TICK - 20);
      chk1(pulse_lamp, 1'b1);
      cyc(40);
      chk1(pulse_lamp, 1'b0);
      @(posedge clk);
      pps_pulse <= 1'b1;
      cyc(5);
      chk1(pulse_lamp, 1'b1);
      @(posedge clk);
      pps_pulse <= 1'b0;
      pps_valid <= 1'b0;
      cyc(4);
      chk1(pulse_lamp, 1'b0);
      @(posedge clk);
      pps_pulse <= 1'b1;
      cyc(5);
      chk1(pulse_lamp, 1'b0);
      @(posedge clk);
      pps_pulse <= 1'b0;
   endtask

   task automatic t_ovl();
      int i;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         if (i < 4) begin
            adc_overload <= 4'h1 << i;
         end else begin
            fifo_overrun <= 4'h1 << (i - 4);
         end
         cyc(10);
         chkv({12'h000, overload_lamp}, 16'h0001 << (i % 4));
         @(posedge clk);
         adc_overload <= 4'h0;
         fifo_overrun <= 4'h0;
         cyc(50 * TICK - 20);
         chkv({12'h000, overload_lamp}, 16'h0001 << (i % 4));
         cyc(40);
         chkv({12'h000, overload_lamp}, 16'h0000);
      end
   endtask

   // Two samples back to back; without a sample clock both must vanish
   task automatic t_gate(input logic det);
      @(posedge clk);
      samp_clk_detect <= det;
      cyc(5);
      @(posedge clk);
      samp_valid_in <= 1'b1;
      samp_data_in <= 16'ha5c3;
      @(posedge clk);
      samp_data_in <= 16'h3c5a;
      #1;
      chk1(samp_valid_out, det);
      if (det) begin
         chkv(samp_data_out, 16'ha5c3);
      end else begin
         chkv(samp_data_out, 16'h0000);
      end
      @(posedge clk);
      samp_valid_in <= 1'b0;
      #1;
      chk1(samp_valid_out, det);
      if (det) begin
         chkv(samp_data_out, 16'h3c5a);
      end else begin
         chkv(samp_data_out, 16'h0000);
      end
      cyc(1);
      chk1(samp_valid_out, 1'b0);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(4);
      t_static();
      t_link(SPEED_GEN3, 1'b1, 1'b1, 600, 8'h00);
      t_link(SPEED_GEN2, 1'b1, 1'b1, 4100, 8'h02);
      t_link(SPEED_GEN1, 1'b1, 1'b1, 4100, 8'h01);
      t_link(SPEED_GEN3, 1'b0, 1'b0, 600, 8'h00);
      t_link(SPEED_NONE, 1'b1, 1'b0, 600, 8'h00);
      t_pps();
      t_ovl();
      t_gate(1'b0);
      t_gate(1'b1);
      test_done();
   end
endmodule // front_panel_status_leds_test
`default_nettype wire
